// ===== src/seci_consts.vh
/*
  Constants of the serial EEPROM command interface: opcodes, status bit
  positions, reset values, address and page sizes, and timing figures.
  Assumes it is included by bare name from the design files and the test bench.
*/
//
// Function
// - first byte after select is an opcode: latch set, array read, array write
// - 8-bit opcode register; latch clear, status read, status write opcodes
// - opcode, address and data sampled on rising serial clock, modes 0 and 3
// - read data changes on each falling serial clock edge
// - select high floats the output and idles, except a running write cycle
// - a new command is accepted only after a select falling edge
// - write cycle starts on select rising after a complete valid write
// - sixteen address clocks follow read or write; upper unused bits ignored
// - busy status bit is 1 during a write cycle, 0 when ready
// - write latch set only by latch set, cleared by latch clear
// - block protect pair selects none, top quarter, upper half, or whole array
// - block protect loaded only by status write; protected range is read only
// - protect pin low with enable set blocks status writes, not free array
// - pin ignored when enable clear; latch clear protects everything
// - protect pin falling during selection aborts pending status write
// - hold pauses: output floats and serial input is ignored
// - read auto-increments pointer, wrapping past top to zero
// - status read answers at any time, even during a write cycle
// - latch clear after power up; host waits power-up delay
// - latch set takes effect only after select rises
// - writes aimed inside the protected range are discarded
// - during a write cycle only status read is honoured
// - up to 32 page bytes, offset wraps within the page
// - write latch clears when a write cycle completes
// - status write changes only bits 2, 3 and 7
`ifndef SECI_CONSTS_VH
`define SECI_CONSTS_VH

`define SECI_OP_LSET     8'h06
`define SECI_OP_LCLR     8'h04
`define SECI_OP_STRD     8'h05
`define SECI_OP_STWR     8'h01
`define SECI_OP_READ     8'h03
`define SECI_OP_WRITE    8'h02

`define SECI_SR_PINEN    7
`define SECI_SR_BPHI     3
`define SECI_SR_BPLO     2

`define SECI_ADDR_W      11
`define SECI_MEM_BYTES   2048
`define SECI_PAGE_BYTES  32

// pin sync reset: {hold_n, wp_n, cs_n, sck, si}
`define SECI_PIN_RST     5'h1C
`define SECI_BP_RST      2'h0
`define SECI_PINEN_RST   1'b0

`define SECI_CLK_MHZ     200
`define SECI_TPU_US      1000
`define SECI_TWC_US      5000

`endif

// ===== src/seci_buf2.v
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset, and that the consumer
  may hold out_ready low for any number of cycles.
*/
`timescale 1ns/1ps
module seci_buf2 #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // fill side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  // drain side
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);
  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg         wr_sel;
  reg         rd_sel;
  reg [1:0]   fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data  = rd_sel ? slot1 : slot0;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_sel <= 1'b0;
      rd_sel <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) begin
        wr_sel <= ~wr_sel;
      end
      if (pop) begin
        rd_sel <= ~rd_sel;
      end
      if (push & ~pop) begin
        fill <= fill + 2'h1;
      end else if (pop & ~push) begin
        fill <= fill - 2'h1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (push & ~wr_sel) begin
      slot0 <= in_data;
    end
    if (push & wr_sel) begin
      slot1 <= in_data;
    end
  end
endmodule // seci_buf2

// ===== src/seci_core.v
/*
  Serial EEPROM target: SPI modes 0 and 3, six opcodes, 2 KiB array,
  32-byte page writes, status register with block and pin protection, hold.
  Assumes all pins are asynchronous to clk_sys and the serial clock is well
  below a quarter of clk_sys, so every edge is seen after synchronisation.
*/
`timescale 1ns/1ps
`include "seci_consts.vh"
module seci_core #(
  parameter PWRUP_CYC = `SECI_TPU_US * `SECI_CLK_MHZ,
  parameter WCYC_CYC  = `SECI_TWC_US * `SECI_CLK_MHZ
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // serial target pins
  input  wire cs_n,
  input  wire sck,
  input  wire si,
  input  wire hold_n,
  input  wire wp_n,
  output reg  so_out,
  output reg  so_oe
);
  localparam [1:0] PH_OP   = 2'h0;
  localparam [1:0] PH_ADDR = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;
  localparam [1:0] PH_IGN  = 2'h3;
  localparam [1:0] K_NONE  = 2'h0;
  localparam [1:0] K_READ  = 2'h1;
  localparam [1:0] K_WRITE = 2'h2;
  localparam [1:0] K_STWR  = 2'h3;
  // counts are cut to the counter width on purpose
  localparam integer PU_LAST_I = PWRUP_CYC - 1;
  localparam integer WC_LAST_I = WCYC_CYC - 1;
  localparam [20:0] PU_LAST = PU_LAST_I[20:0];
  localparam [20:0] WC_LAST = WC_LAST_I[20:0];

  reg  [4:0]  pin_m;
  reg  [4:0]  pin_s;
  reg         sck_d;
  reg         cs_d;
  reg  [20:0] pu_cnt;
  reg         pu_done;
  reg         hold_act;
  reg         sel;
  reg  [1:0]  phase;
  reg  [1:0]  cmd_kind;
  reg  [2:0]  bcnt;
  reg  [7:0]  rx_sr;
  reg         addr_lo_next;
  reg  [7:0]  addr_hi;
  reg  [10:0] ptr;
  reg  [7:0]  out_sr;
  reg  [2:0]  tcnt;
  reg         tx_on;
  reg         tx_go;
  reg         write_latch_flag;
  reg         latch_set_pend;
  reg         protect_pin_enable;
  reg         bp_hi;
  reg         bp_lo;
  reg         wr_ok;
  reg         sr_pend;
  reg         sr_abort;
  reg  [7:0]  sr_data;
  reg         push_v;
  reg  [7:0]  push_d;
  reg  [4:0]  pw_off;
  reg  [31:0] pw_mask;
  reg         pw_gap;
  reg         commit_req;
  reg         busy;
  reg         wkind_sr;
  reg  [20:0] bz_cnt;
  reg  [5:0]  cidx;
  reg  [5:0]  wbase;
  reg  [7:0]  mem  [0:`SECI_MEM_BYTES-1];
  reg  [7:0]  pbuf [0:`SECI_PAGE_BYTES-1];

  wire        push_rdy;
  wire        buf_v;
  wire [7:0]  buf_d;

  function prot;
    input [1:0]  bp;
    input [10:0] a;
    begin
      case (bp)
        2'h0:    prot = 1'b0;
        2'h1:    prot = (a[10:9] == 2'h3);
        2'h2:    prot = a[10];
        default: prot = 1'b1;
      endcase
    end
  endfunction

  wire        si_s      = pin_s[0];
  wire        sck_s     = pin_s[1];
  wire        cs_s      = pin_s[2];
  wire        wp_s      = pin_s[3];
  wire        hold_s    = pin_s[4];
  wire        sck_rise  = sck_s & ~sck_d;
  wire        sck_fall  = ~sck_s & sck_d;
  wire        cs_fall   = ~cs_s & cs_d;
  wire        cs_rise   = cs_s & ~cs_d;
  wire        live      = sel & ~hold_act;
  wire        rx_edge   = live & sck_rise;
  wire        tx_edge   = live & sck_fall & tx_on;
  wire [7:0]  rx_byte   = {rx_sr[6:0], si_s};
  wire        byte_done = rx_edge & (bcnt == 3'h7);
  wire [10:0] new_addr  = {addr_hi[2:0], rx_byte};
  wire [10:0] ptr_inc   = ptr + 11'h001;
  wire [7:0]  status    = {protect_pin_enable, 1'b0, 1'b1, 1'b0,
                           bp_hi, bp_lo, write_latch_flag, busy};
  wire        hw_lock   = protect_pin_enable & ~wp_s;
  wire        drain     = buf_v & ~pw_gap;
  wire        copy_we   = busy & ~wkind_sr & ~cidx[5] & pw_mask[cidx[4:0]];

  // two-stage synchronisers for all pins
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_m <= `SECI_PIN_RST;
      pin_s <= `SECI_PIN_RST;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      pin_m <= {hold_n, wp_n, cs_n, sck, si};
      pin_s <= pin_m;
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pu_cnt  <= 21'h000000;
      pu_done <= 1'b0;
    end else if (!pu_done) begin
      pu_cnt  <= pu_cnt + 21'h000001;
      pu_done <= (pu_cnt == PU_LAST);
    end
  end

  // hold enters and leaves only with the clock low
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_act <= 1'b0;
    end else if (!sck_s) begin
      hold_act <= ~hold_s;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sel        <= 1'b0;
      phase      <= PH_IGN;
      cmd_kind   <= K_NONE;
      bcnt       <= 3'h0;
      rx_sr      <= 8'h00;
      addr_lo_next <= 1'b0;
      addr_hi    <= 8'h00;
      ptr        <= 11'h000;
      out_sr     <= 8'h00;
      tcnt       <= 3'h0;
      tx_on      <= 1'b0;
      tx_go      <= 1'b0;
      write_latch_flag   <= 1'b0;
      latch_set_pend     <= 1'b0;
      protect_pin_enable <= `SECI_PINEN_RST;
      {bp_hi, bp_lo} <= `SECI_BP_RST;
      wr_ok      <= 1'b0;
      sr_pend    <= 1'b0;
      sr_abort   <= 1'b0;
      sr_data    <= 8'h00;
      push_v     <= 1'b0;
      push_d     <= 8'h00;
      pw_off     <= 5'h00;
      pw_mask    <= 32'h00000000;
      pw_gap     <= 1'b0;
      commit_req <= 1'b0;
      busy       <= 1'b0;
      wkind_sr   <= 1'b0;
      bz_cnt     <= 21'h000000;
      cidx       <= 6'h00;
      wbase      <= 6'h00;
      so_out     <= 1'b0;
      so_oe      <= 1'b0;
    end else begin
      if (cs_fall & pu_done) begin
        sel          <= 1'b1;
        phase        <= PH_OP;
        cmd_kind     <= K_NONE;
        bcnt         <= 3'h0;
        addr_lo_next <= 1'b0;
        tx_on        <= 1'b0;
        tcnt         <= 3'h0;
        tx_go        <= 1'b0;
        latch_set_pend <= 1'b0;
        wr_ok        <= 1'b0;
        sr_pend      <= 1'b0;
        sr_abort     <= 1'b0;
      end
      // rising select hands over to commit
      if (cs_rise & sel) begin
        sel        <= 1'b0;
        tx_on      <= 1'b0;
        commit_req <= 1'b1;
      end
      if (sel & sr_pend & hw_lock) begin
        sr_abort <= 1'b1;
      end
      if (push_v & push_rdy) begin
        push_v <= 1'b0;
      end
      if (rx_edge) begin
        rx_sr <= rx_byte;
        bcnt  <= bcnt + 3'h1;
      end
      if (byte_done) begin
        case (phase)
          PH_OP: begin
            phase <= PH_IGN;
            if (rx_byte == `SECI_OP_STRD) begin
              out_sr <= status;
              tcnt   <= 3'h0;
              tx_on  <= 1'b1;
            end else if (!busy) begin
              case (rx_byte)
                // latch set waits for select high
                `SECI_OP_LSET: latch_set_pend <= 1'b1;
                `SECI_OP_LCLR: write_latch_flag <= 1'b0;
                `SECI_OP_READ: begin
                  phase    <= PH_ADDR;
                  cmd_kind <= K_READ;
                end
                `SECI_OP_WRITE: begin
                  phase    <= PH_ADDR;
                  cmd_kind <= K_WRITE;
                end
                `SECI_OP_STWR: begin
                  phase    <= PH_DATA;
                  cmd_kind <= K_STWR;
                end
                default: phase <= PH_IGN;
              endcase
            end
          end
          // two address bytes, upper bits dropped
          PH_ADDR: begin
            addr_lo_next <= ~addr_lo_next;
            if (!addr_lo_next) begin
              addr_hi <= rx_byte;
            end else begin
              phase <= PH_DATA;
              ptr   <= new_addr;
              if (cmd_kind == K_READ) begin
                out_sr <= mem[new_addr];
                tcnt   <= 3'h0;
                tx_on  <= 1'b1;
              end else begin
                wr_ok   <= write_latch_flag & ~prot({bp_hi, bp_lo}, new_addr);
                pw_off  <= new_addr[4:0];
                pw_mask <= 32'h00000000;
              end
            end
          end
          PH_DATA: begin
            if (cmd_kind == K_WRITE) begin
              if (wr_ok) begin
                push_v <= 1'b1;
                push_d <= rx_byte;
              end
            end else if (cmd_kind == K_STWR) begin
              phase   <= PH_IGN;
              sr_data <= rx_byte;
              sr_pend <= 1'b1;
              // latch clear or pin lock refuses
              sr_abort <= hw_lock | ~write_latch_flag;
            end
          end
          default: phase <= PH_IGN;
        endcase
      end
      if (tx_edge) begin
        tx_go  <= 1'b1;
        so_out <= out_sr[7];
        tcnt   <= tcnt + 3'h1;
        if (tcnt == 3'h7) begin
          if (cmd_kind == K_READ) begin
            out_sr <= mem[ptr_inc];
            ptr    <= ptr_inc;
          end else begin
            out_sr <= status;
          end
        end else begin
          out_sr <= {out_sr[6:0], 1'b0};
        end
      end
      // drive only from the first falling edge, so no stale bit shows
      // float when deselected or held
      so_oe <= sel & tx_on & (tx_go | tx_edge) & ~hold_act & ~cs_rise;
      // page offset wraps inside the page
      pw_gap <= drain;
      if (drain) begin
        pw_mask[pw_off] <= 1'b1;
        pw_off          <= pw_off + 5'h01;
      end
      // commit waits until every buffered byte is in the page
      if (commit_req & ~sel & ~push_v & ~buf_v) begin
        commit_req <= 1'b0;
        cmd_kind   <= K_NONE;
        if (latch_set_pend) begin
          write_latch_flag <= 1'b1;
        end
        if ((cmd_kind == K_WRITE) & wr_ok & (pw_mask != 32'h00000000) & (bcnt == 3'h0)) begin
          busy     <= 1'b1;
          wkind_sr <= 1'b0;
          bz_cnt   <= 21'h000000;
          cidx     <= 6'h00;
          wbase    <= ptr[10:5];
        end else if ((cmd_kind == K_STWR) & sr_pend & ~sr_abort & (bcnt == 3'h0)) begin
          busy     <= 1'b1;
          wkind_sr <= 1'b1;
          bz_cnt   <= 21'h000000;
          cidx     <= 6'h20;
        end else if (!busy) begin
          // an empty selection during the copy must not wipe the page mask
          pw_mask <= 32'h00000000;
        end
      end
      // busy for the full write time
      if (busy) begin
        bz_cnt <= bz_cnt + 21'h000001;
        if (!cidx[5]) begin
          cidx <= cidx + 6'h01;
        end
        if (bz_cnt == WC_LAST) begin
          busy    <= 1'b0;
          pw_mask <= 32'h00000000;
          write_latch_flag <= 1'b0;
          if (wkind_sr) begin
            // only bits 7, 3, 2 change
            protect_pin_enable <= sr_data[`SECI_SR_PINEN];
            // protect bits from status write only
            bp_hi <= sr_data[`SECI_SR_BPHI];
            bp_lo <= sr_data[`SECI_SR_BPLO];
          end
        end
      end
    end
  end

  // array and page storage carry no reset
  always @(posedge clk_sys) begin
    if (drain) begin
      pbuf[pw_off] <= buf_d;
    end
    if (copy_we) begin
      mem[{wbase, cidx[4:0]}] <= pbuf[cidx[4:0]];
    end
  end

  // page data path; a slow page store stalls the byte holder, not the array
  seci_buf2 #(
    .W (8)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push_v),
    .in_data   (push_d),
    .in_ready  (push_rdy),
    .out_valid (buf_v),
    .out_data  (buf_d),
    .out_ready (~pw_gap)
  );
endmodule // seci_core

// ===== tb/seci_core_properties.sv
/*
  Checker on the serial pins of seci_core, bound to every instance.
  Assumes a host whose serial clock half period is near 24 ns.
*/
`timescale 1ns/1ps
module seci_core_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [7:0] sel_cnt;
  // cycles spent selected; a reply needs a full opcode first
  always @(posedge clk_sys) begin
    if (!rst_n || cs_n) sel_cnt <= 8'h00;
    else if (sel_cnt != 8'hFF) sel_cnt <= sel_cnt + 8'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rst_quiet; $past(!rst_n) |-> !so_oe && !so_out; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
  property p_standby; cs_n [*6] |-> !so_oe; endproperty
  a_standby: assert property (p_standby)
    else $error("output driven while deselected");
  property p_cs_rise; $rose(cs_n) |-> ##[1:5] !so_oe; endproperty
  a_cs_rise: assert property (p_cs_rise)
    else $error("output not released after deselect");
  property p_hold_fall; $fell(hold_n) |-> ##[1:5] !so_oe; endproperty
  a_hold_fall: assert property (p_hold_fall)
    else $error("output not released on hold");
  property p_hold_held; !hold_n [*6] |-> !so_oe; endproperty
  a_hold_held: assert property (p_hold_held)
    else $error("output driven during hold");
  property p_so_edge; so_oe && $past(so_oe) && $changed(so_out) |-> !$past(sck, 2); endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("output bit changed away from a falling clock");
  property p_oe_rise; $rose(so_oe) |-> !cs_n && hold_n && !$past(sck, 2); endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enabled out of turn");
  property p_oe_late; $rose(so_oe) |-> sel_cnt >= 8'h3C; endproperty
  a_oe_late: assert property (p_oe_late)
    else $error("output enabled before an opcode was received");
endmodule // seci_core_checker

bind seci_core seci_core_checker u_checker (
  .clk_sys(clk_sys),
  .rst_n  (rst_n),
  .cs_n   (cs_n),
  .sck    (sck),
  .hold_n (hold_n),
  .so_out (so_out),
  .so_oe  (so_oe)
);

// ===== tb/seci_host_model.sv
/*
  Behavioural serial host in mode 0, driven through its tasks.
  Assumes the target samples on rising and shifts on falling clock edges.
*/
`timescale 1ns/1ps
module seci_host_model (
  // pins toward the target
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  // target output
  input wire logic so_out,
  input wire logic so_oe
);
  localparam time HALF = 24;
  logic last_so = 1'b0;
  wire  so_line;
  // a floating line must never read back as the last bit
  always @(so_out or so_oe) if (so_oe) last_so = so_out;
  assign so_line = so_oe ? so_out : ~last_so;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task sel(); begin cs_n = 1'b0; #HALF; end endtask
  // high time kept above 100 ns
  task desel(); begin #HALF; cs_n = 1'b1; #(5*HALF); end endtask
  // shift on fall, sample on rise
  task xb(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si = tx[i];
        #HALF sck = 1'b1;
        rx[i] = so_line;
        #HALF sck = 1'b0;
      end
    end
  endtask
  // hold moves only while clock low
  task pause(); begin #HALF hold_n = 1'b0; #(4*HALF) hold_n = 1'b1; #HALF; end endtask
endmodule // seci_host_model

// ===== tb/seci_core_test.sv
/*
  Self-checking bench of seci_core against a behavioural serial host.
  Assumes short power-up and write-cycle counts set below.
*/
`timescale 1ns/1ps
`include "seci_consts.vh"
module seci_core_test;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wp_n    = 1'b1;
  wire         cs_n, sck, si, hold_n, so_out, so_oe;
  logic [31:0] lfsr    = 32'h0001673C;
  logic [7:0]  mem_exp [0:2047];
  logic [7:0]  rx;
  integer      err_count = 0;
  integer      checked   = 0;
  integer      k;
  always #2.5 clk_sys = ~clk_sys;
  seci_core #(.PWRUP_CYC(8), .WCYC_CYC(600)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out),
    .so_oe(so_oe));
  seci_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [11:0] prot_lo(input logic [1:0] bp);
    return (bp == 2'h0) ? 12'h800 : (bp == 2'h1) ? 12'h600 : (bp == 2'h2) ? 12'h400 : 12'h000;
  endfunction
  function automatic logic [7:0] stat(input logic pin_en, input logic [1:0] bp, input logic wl,
                                      input logic busy);
    return {pin_en, 3'b010, bp, wl, busy};
  endfunction
  task report_and_stop();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task cmd(input logic [7:0] op); host.sel(); host.xb(op, rx); host.desel(); endtask
  task f2(input logic [7:0] op, input logic [7:0] v);
    host.sel(); host.xb(op, rx); host.xb(v, rx); host.desel();
  endtask
  task cst(input logic [7:0] exp, input string msg); f2(`SECI_OP_STRD, 8'h00); chk8(rx, exp, msg);
  endtask
  task set_wp(input logic v); @(posedge clk_sys); #1 wp_n = v; endtask
  task wait_ready();
    integer n;
    for (n = 0; n < 20; n++) begin
      f2(`SECI_OP_STRD, 8'h00);
      if (rx[0] === 1'b0) return;
    end
    err_count++;
    $display("CHECK FAILED %0t busy never cleared", $time);
    report_and_stop();
  endtask
  // page write of n random bytes; keep marks bytes expected to land
  task wr(input logic [15:0] a, input integer n, input logic keep);
    logic [7:0] d;
    integer j;
    host.sel(); host.xb(`SECI_OP_WRITE, rx); host.xb(a[15:8], rx); host.xb(a[7:0], rx);
    for (j = 0; j < n; j++) begin
      d = rnd();
      host.xb(d, rx);
      if (keep) mem_exp[{a[10:5], a[4:0] + j[4:0]}] = d;
    end
    host.desel();
  endtask
  task rd(input logic [15:0] a, input integer n, input integer hold_at);
    logic [10:0] ea;
    integer j;
    host.sel(); host.xb(`SECI_OP_READ, rx); host.xb(a[15:8], rx); host.xb(a[7:0], rx);
    for (j = 0; j < n; j++) begin
      ea = a[10:0] + j[10:0];
      host.xb(8'h00, rx);
      chk8(rx, mem_exp[ea], "array read");
      if (j == hold_at) host.pause();
    end
    host.desel();
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    cst(8'h20, "power-up status");
    wr(16'h0040, 1, 1'b0);
    cst(8'h20, "write with latch clear");
    host.sel(); host.xb(`SECI_OP_LSET, rx); wr(16'h0040, 1, 1'b0);
    f2(`SECI_OP_STRD, 8'h00);
    chk8(rx & 8'h01, 8'h00, "write in latch-set frame");
    cmd(`SECI_OP_LCLR);
    cst(8'h20, "latch clear");
    cmd(`SECI_OP_LSET);
    cst(8'h22, "latch set");
    wr(16'h07E5, 32, 1'b1);
    cst(8'h23, "busy status");
    f2(`SECI_OP_STWR, 8'h8C);
    cst(8'h23, "busy holds");
    wait_ready();
    cst(8'h20, "status after write");
    cmd(`SECI_OP_LSET);
    wr(16'h0000, 33, 1'b1);
    wait_ready();
    rd(16'hF7E0, 64, 40);
    for (k = 1; k < 4; k++) begin
      cmd(`SECI_OP_LSET);
      f2(`SECI_OP_STWR, {1'b0, 3'b111, k[1:0], 2'b11});
      wait_ready();
      cst(stat(1'b0, k[1:0], 1'b0, 1'b0), "protect bits");
      cmd(`SECI_OP_LSET);
      wr({4'h0, prot_lo(k[1:0])}, 1, 1'b0);
      cst(stat(1'b0, k[1:0], 1'b1, 1'b0), "protected write");
      if (k < 3) begin
        wr({4'h0, prot_lo(k[1:0]) - 12'h020}, 1, 1'b1);
        cst(stat(1'b0, k[1:0], 1'b1, 1'b1), "free write");
        wait_ready();
      end
    end
    cmd(`SECI_OP_LSET);
    f2(`SECI_OP_STWR, 8'h80);
    wait_ready();
    cst(8'hA0, "pin protect on");
    set_wp(1'b0);
    cmd(`SECI_OP_LSET);
    f2(`SECI_OP_STWR, 8'h8C);
    cst(8'hA2, "status write blocked");
    wr(16'h0100, 1, 1'b1);
    cst(8'hA3, "array write under pin");
    wait_ready();
    set_wp(1'b1);
    cmd(`SECI_OP_LSET);
    host.sel(); host.xb(`SECI_OP_STWR, rx); host.xb(8'h8C, rx);
    set_wp(1'b0);
    host.desel();
    cst(8'hA2, "pin fall aborts status write");
    set_wp(1'b1);
    f2(`SECI_OP_STWR, 8'h00);
    wait_ready();
    cst(8'h20, "pin high allows status write");
    set_wp(1'b0);
    cmd(`SECI_OP_LSET);
    f2(`SECI_OP_STWR, 8'h04);
    wait_ready();
    cst(8'h24, "pin ignored without enable");
    rd(16'h0100, 1, -1);
    report_and_stop();
  end
endmodule // seci_core_test
